// File: verification/tb_rtc_control_register.sv
`timescale 1ns/100ps
`default_nettype none
module tb_rtc_control_register;
    import rtcc_pkg::*;
    // ==========================================
    // stimulus and observed signals
    logic pclk = 1'b0;
    logic rtc_source_clock = 1'b0;
    logic presetn = 1'b0;
    logic rtc_src_rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic write_protect = 1'b0;
    logic match_event = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic counter_tick_clock;
    logic counter_run;
    logic counter_clear;
    logic soft_reset_out;
    logic hour_format_select;
    rtcc_mode_t mode_out;
    int fail_count = 0;
    int checks_done = 0;
    logic [31:0] rd;
    logic err;
    logic [31:0] cfg;
    int srst_pulses = 0;

    always #20 pclk = ~pclk;
    // source clock unrelated in phase to the bus clock
    always #15.3 rtc_source_clock = ~rtc_source_clock;
    // count soft reset pulses seen in the counter domain
    always @(posedge rtc_source_clock) begin
        if (soft_reset_out === 1'b1) srst_pulses++;
    end

    rtcc_ctrl dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .write_protect(write_protect), .rtc_source_clock(rtc_source_clock),
        .rtc_src_rst_n(rtc_src_rst_n), .match_event(match_event),
        .counter_tick_clock(counter_tick_clock), .counter_run(counter_run),
        .counter_clear(counter_clear), .soft_reset_out(soft_reset_out),
        .mode_out(mode_out), .hour_format_select(hour_format_select)
    );

    // ==========================================
    // report and compare
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic timed_out();
        fail_count++;
        $display("CHECK FAILED %0t wait limit used up", $time);
        print_verdict();
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t word got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t flag got %b exp %b", $time, got, exp);
        end
    endtask

    // ==========================================
    // apb master
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) timed_out();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            apb(1'b0, RTCC_STATUS_OFS, 32'h0);
            n++;
        end while (rd[RTCC_SYNC_PENDING_FLAG_BIT] !== 1'b0 && n < 50);
        if (rd[RTCC_SYNC_PENDING_FLAG_BIT] !== 1'b0) timed_out();
    endtask

    task automatic tick_gap(output int n);
        // first pass lands on a tick edge, second counts source edges to the next
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(posedge rtc_source_clock);
                n++;
            end while (counter_tick_clock !== 1'b1 && n < 3000);
            if (counter_tick_clock !== 1'b1) timed_out();
        end
    endtask

    // ==========================================
    // scenarios
    task automatic s_reset();
        apb(1'b0, RTCC_CTRL_OFS, 32'h0);
        check_word(rd, {16'h0000, RTCC_CTRL_RST});
        apb(1'b0, RTCC_STATUS_OFS, 32'h0);
        check_bit(rd[RTCC_SYNC_PENDING_FLAG_BIT], 1'b0);
    endtask

    task automatic s_modes();
        for (int m = 0; m < 3; m++) begin
            // bits reserved in this layout are written as zero
            cfg = 32'h0000_0200 | (m << RTCC_MODE_LSB);
            if (m != 1) cfg = cfg | 32'h0000_0080;
            if (m == 2) cfg = cfg | 32'h0000_0040;
            apb(1'b1, RTCC_CTRL_OFS, cfg);
            apb(1'b0, RTCC_CTRL_OFS, 32'h0);
            check_word(rd, cfg);
            check_word({30'h0, mode_out}, m);
            check_bit(hour_format_select, m == 2);
            apb(1'b0, RTCC_STATUS_OFS, 32'h0);
            check_bit(rd[RTCC_SYNC_PENDING_FLAG_BIT], 1'b0);
            check_bit(counter_clear, 1'b0);
            @(posedge pclk);
            match_event <= 1'b1;
            @(negedge pclk);
            check_bit(counter_clear, m != 1);
            @(posedge pclk);
            match_event <= 1'b0;
        end
    endtask

    task automatic s_enable();
        int n;
        apb(1'b1, RTCC_CTRL_OFS, cfg | 32'h2);
        apb(1'b0, RTCC_CTRL_OFS, 32'h0);
        check_word(rd, cfg | 32'h2);
        apb(1'b0, RTCC_STATUS_OFS, 32'h0);
        check_bit(rd[RTCC_SYNC_PENDING_FLAG_BIT], 1'b1);
        wait_idle();
        check_bit(counter_run, 1'b1);
        tick_gap(n);
        check_word(n, 32'd4);
        apb(1'b1, RTCC_CTRL_OFS, 32'h0000_0502);
        apb(1'b0, RTCC_CTRL_OFS, 32'h0);
        check_word(rd, cfg | 32'h2);
        apb(1'b1, RTCC_CTRL_OFS, 32'h0);
        apb(1'b0, RTCC_CTRL_OFS, 32'h0);
        check_word(rd, cfg);
        wait_idle();
        check_bit(counter_run, 1'b0);
    endtask

    task automatic s_protect();
        write_protect <= 1'b1;
        apb(1'b1, RTCC_CTRL_OFS, 32'h0000_0300);
        apb(1'b0, RTCC_CTRL_OFS, 32'h0);
        check_word(rd, cfg);
        write_protect <= 1'b0;
        // the lock register set by software has the same effect
        apb(1'b1, RTCC_PROT_OFS, 32'h0000_0001);
        apb(1'b1, RTCC_CTRL_OFS, 32'h0000_0300);
        apb(1'b0, RTCC_CTRL_OFS, 32'h0);
        check_word(rd, cfg);
        apb(1'b0, RTCC_PROT_OFS, 32'h0);
        check_word(rd, 32'h0000_0001);
        apb(1'b1, RTCC_PROT_OFS, 32'h0);
    endtask

    task automatic s_soft_reset();
        apb(1'b1, RTCC_CTRL_OFS, cfg | 32'h2);
        wait_idle();
        apb(1'b1, RTCC_CTRL_OFS, 32'h0000_0501);
        apb(1'b0, RTCC_CTRL_OFS, 32'h0);
        check_bit(rd[RTCC_SOFT_RESET_BIT_BIT], 1'b1);
        apb(1'b0, RTCC_STATUS_OFS, 32'h0);
        check_bit(rd[RTCC_SYNC_PENDING_FLAG_BIT], 1'b1);
        wait_idle();
        apb(1'b0, RTCC_CTRL_OFS, 32'h0);
        check_word(rd, 32'h0);
        check_word(srst_pulses, 32'd1);
        check_bit(counter_run, 1'b0);
    endtask

    task automatic s_unmapped();
        apb(1'b0, 12'h0FC, 32'h0);
        check_bit(err, 1'b1);
        apb(1'b0, RTCC_CTRL_OFS, 32'h0);
        check_bit(err, 1'b0);
    endtask

    // ==========================================
    // main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rtc_src_rst_n <= 1'b1;
        s_reset();
        s_modes();
        s_enable();
        s_protect();
        s_soft_reset();
        s_unmapped();
        print_verdict();
    end
endmodule // tb_rtc_control_register
`default_nettype wire

// File: verilog/rtcc_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - tick is source clock over two-power prescaler
// - prescaler 11:8, mode 3:2, enable 1, reset 0
// - mode 0 wide, 1 narrow, 2 calendar
// - clear_on_match zeroes counter on match
// - clear_on_match in every mode but narrow
// - clear_on_match writable only while disabled
// - unsynchronised fields apply directly, no busy
// - protected fields frozen while enabled; write-protect
// - enable reads back at once, busy until applied
// - enable and soft reset writable while enabled
// - soft reset clears registers except the lock, disables peripheral
// - soft reset write discards other fields
// - soft reset reads one, busy until done
// - reserved bits read zero
// - hour format bit six, calendar only, disabled
module rtcc_ctrl (
    // bus clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // access controller lock
    input wire logic write_protect,
    // counter domain
    input wire logic rtc_source_clock,
    input wire logic rtc_src_rst_n,
    input wire logic match_event,
    output logic counter_tick_clock,
    output logic counter_run,
    output logic counter_clear,
    output logic soft_reset_out,
    output rtcc_pkg::rtcc_mode_t mode_out,
    output logic hour_format_select
);
    import rtcc_pkg::*;
    // ==========================================
    // bus-side state
    logic [3:0] presc_ff, nxt_presc;
    rtcc_mode_t mode_ff, nxt_mode;
    logic enable_ff, nxt_enable;
    logic clear_on_match_ff, nxt_clear_on_match;
    logic hourfmt_ff, nxt_hourfmt;
    logic soft_reset_bit_ff, nxt_soft_reset_bit;
    logic lock_ff, nxt_lock;
    rtcc_sy_t sy_ff, nxt_sy;
    logic req_ff, nxt_req;
    logic [31:0] rdata_ff, nxt_rdata;
    logic ack_sync;
    logic wr, rd, ctrl_hit, prot_hit, stat_hit;
    logic rd_setup;
    logic sync_pending_flag;
    logic applied_en;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    // reads are captured at the setup edge so prdata comes from a flop
    assign rd_setup = psel && !penable && !pwrite;
    assign ctrl_hit = paddr == RTCC_CTRL_OFS;
    assign stat_hit = paddr == RTCC_STATUS_OFS;
    assign prot_hit = paddr == RTCC_PROT_OFS;
    assign sync_pending_flag = sy_ff != RTCC_SY_IDLE;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(ctrl_hit || stat_hit || prot_hit);

    function automatic logic [15:0] ctrl_view(input logic [3:0] p, input logic [1:0] m, input logic e,
                                              input logic s, input logic mc, input logic hf);
        logic [15:0] v;
        v = 16'h0000;
        v[RTCC_PRESC_LSB +: 4] = p;
        v[RTCC_MODE_LSB +: 2] = m;
        v[RTCC_ENABLE_BIT] = e;
        v[RTCC_SOFT_RESET_BIT_BIT] = s;
        if (m != RTCC_MODE_NARROW) begin
            v[RTCC_CLEAR_ON_MATCH_BIT] = mc;
        end
        if (m == RTCC_MODE_CAL) begin
            v[RTCC_HOURFMT_BIT] = hf;
        end
        return v;
    endfunction

    // ==========================================
    // register writes and sync handshake
    always_comb begin
        nxt_presc = presc_ff;
        nxt_mode = mode_ff;
        nxt_enable = enable_ff;
        nxt_clear_on_match = clear_on_match_ff;
        nxt_hourfmt = hourfmt_ff;
        nxt_soft_reset_bit = soft_reset_bit_ff;
        nxt_lock = lock_ff;
        nxt_sy = sy_ff;
        nxt_req = req_ff;
        nxt_rdata = rdata_ff;
        case (sy_ff)
            RTCC_SY_REQ: begin
                if (ack_sync == req_ff) begin
                    nxt_sy = RTCC_SY_ACK;
                end
            end
            RTCC_SY_ACK: begin
                // far side has taken the value; soft reset completes here
                nxt_sy = RTCC_SY_IDLE;
                nxt_soft_reset_bit = 1'b0;
            end
            default: begin
                nxt_sy = sy_ff;
            end
        endcase
        if (wr && prot_hit) begin
            nxt_lock = pwdata[0];
        end
        if (wr && ctrl_hit && !write_protect && !lock_ff && !soft_reset_bit_ff) begin
            if (pwdata[RTCC_SOFT_RESET_BIT_BIT]) begin
                // everything but the lock register returns to reset
                nxt_presc = RTCC_CTRL_RST[11:8];
                nxt_mode = RTCC_MODE_WIDE;
                nxt_clear_on_match = 1'b0;
                nxt_hourfmt = 1'b0;
                nxt_enable = 1'b0;
                nxt_soft_reset_bit = 1'b1;
                nxt_req = !req_ff;
                nxt_sy = RTCC_SY_REQ;
            end else begin
                if (!enable_ff) begin
                    nxt_presc = pwdata[RTCC_PRESC_LSB +: 4];
                    nxt_mode = rtcc_mode_t'(pwdata[RTCC_MODE_LSB +: 2]);
                    nxt_clear_on_match = pwdata[RTCC_CLEAR_ON_MATCH_BIT];
                    nxt_hourfmt = pwdata[RTCC_HOURFMT_BIT];
                end
                if (pwdata[RTCC_ENABLE_BIT] != enable_ff) begin
                    nxt_enable = pwdata[RTCC_ENABLE_BIT];
                    nxt_req = !req_ff;
                    nxt_sy = RTCC_SY_REQ;
                end
            end
        end
        if (rd_setup) begin
            if (ctrl_hit) begin
                nxt_rdata = {16'h0000, ctrl_view(presc_ff, mode_ff, enable_ff, soft_reset_bit_ff, clear_on_match_ff, hourfmt_ff)};
            end else if (stat_hit) begin
                nxt_rdata = 32'h00000000;
                nxt_rdata[RTCC_SYNC_PENDING_FLAG_BIT] = sync_pending_flag;
            end else if (prot_hit) begin
                nxt_rdata = {31'h00000000, lock_ff};
            end else begin
                nxt_rdata = 32'h00000000;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_ff <= 4'h0;
            mode_ff <= RTCC_MODE_WIDE;
            enable_ff <= 1'b0;
            clear_on_match_ff <= 1'b0;
            hourfmt_ff <= 1'b0;
            soft_reset_bit_ff <= 1'b0;
            lock_ff <= 1'b0;
            sy_ff <= RTCC_SY_IDLE;
            req_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
        end else begin
            presc_ff <= nxt_presc;
            mode_ff <= nxt_mode;
            enable_ff <= nxt_enable;
            clear_on_match_ff <= nxt_clear_on_match;
            hourfmt_ff <= nxt_hourfmt;
            soft_reset_bit_ff <= nxt_soft_reset_bit;
            lock_ff <= nxt_lock;
            sy_ff <= nxt_sy;
            req_ff <= nxt_req;
            rdata_ff <= nxt_rdata;
        end
    end
    // read data stands from the setup edge through the access phase
    assign prdata = rdata_ff;

    // ==========================================
    // counter-domain side: toggle handshake
    logic req_sync;
    logic req_seen_ff, nxt_req_seen;
    logic run_ff, nxt_run;
    logic srst_ff, nxt_srst;
    logic en_sync, sr_sync;
    rtcc_sync2 u_req_sync (
        .clk(rtc_source_clock),
        .rst_n(rtc_src_rst_n),
        .din(req_ff),
        .dout(req_sync)
    );
    rtcc_sync2 u_en_sync (
        .clk(rtc_source_clock),
        .rst_n(rtc_src_rst_n),
        .din(enable_ff),
        .dout(en_sync)
    );
    rtcc_sync2 u_sr_sync (
        .clk(rtc_source_clock),
        .rst_n(rtc_src_rst_n),
        .din(soft_reset_bit_ff),
        .dout(sr_sync)
    );
    rtcc_sync2 u_ack_sync (
        .clk(pclk),
        .rst_n(presetn),
        .din(req_seen_ff),
        .dout(ack_sync)
    );
    always_comb begin
        nxt_req_seen = req_seen_ff;
        nxt_run = run_ff;
        nxt_srst = 1'b0;
        if (req_sync != req_seen_ff) begin
            nxt_req_seen = req_sync;
            nxt_run = en_sync && !sr_sync;
            nxt_srst = sr_sync;
        end
    end
    always_ff @(posedge rtc_source_clock or negedge rtc_src_rst_n) begin
        if (!rtc_src_rst_n) begin
            req_seen_ff <= 1'b0;
            run_ff <= 1'b0;
            srst_ff <= 1'b0;
        end else begin
            req_seen_ff <= nxt_req_seen;
            run_ff <= nxt_run;
            srst_ff <= nxt_srst;
        end
    end
    assign applied_en = run_ff;
    rtcc_prescaler u_presc (
        .clk(rtc_source_clock),
        .rst_n(rtc_src_rst_n),
        .run(applied_en),
        .code(presc_ff),
        .tick(counter_tick_clock)
    );
    assign counter_run = applied_en;
    assign soft_reset_out = srst_ff;
    // clear only where the bit is honoured
    assign counter_clear = match_event && clear_on_match_ff && mode_ff != RTCC_MODE_NARROW;
    assign mode_out = mode_ff;
    assign hour_format_select = hourfmt_ff && mode_ff == RTCC_MODE_CAL;

    // ==========================================
    // checks
    AST_BUSY_ON_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        wr && ctrl_hit && !write_protect && !lock_ff && !soft_reset_bit_ff && !pwdata[RTCC_SOFT_RESET_BIT_BIT]
        && pwdata[RTCC_ENABLE_BIT] != enable_ff
        |=> sync_pending_flag && enable_ff == $past(pwdata[RTCC_ENABLE_BIT]))
        else $error("enable write did not raise busy");
    // a soft reset is the one legal way to move these while enabled
    AST_PROTECT: assert property (@(posedge pclk) disable iff (!presetn)
        enable_ff && !soft_reset_bit_ff |=> soft_reset_bit_ff
        || ($stable(presc_ff) && $stable(clear_on_match_ff) && $stable(mode_ff) && $stable(hourfmt_ff)))
        else $error("protected field changed while enabled");
    AST_SOFT_RESET_BIT_DISCARD: assert property (@(posedge pclk) disable iff (!presetn)
        wr && ctrl_hit && !write_protect && !lock_ff && !soft_reset_bit_ff && pwdata[RTCC_SOFT_RESET_BIT_BIT]
        |=> soft_reset_bit_ff && !enable_ff && presc_ff == RTCC_CTRL_RST[11:8] && mode_ff == RTCC_MODE_WIDE
        && !clear_on_match_ff && !hourfmt_ff)
        else $error("soft reset kept written fields");
    AST_SOFT_RESET_BIT_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
        soft_reset_bit_ff |-> sync_pending_flag)
        else $error("soft reset without busy");
    AST_WP: assert property (@(posedge pclk) disable iff (!presetn)
        write_protect |=> $stable(enable_ff) && $stable(presc_ff))
        else $error("write-protected register changed");
    AST_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
        lock_ff |=> $stable(enable_ff) && $stable(presc_ff) && $stable(mode_ff))
        else $error("locked register changed");
    AST_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        mode_ff == RTCC_MODE_NARROW |-> !counter_clear)
        else $error("clear in narrow mode");
    AST_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
        rd && ctrl_hit |-> prdata[15:12] == 4'h0 && prdata[5:4] == 2'h0)
        else $error("reserved bits nonzero");
    AST_RSVD_LAYOUT: assert property (@(posedge pclk) disable iff (!presetn)
        rd && ctrl_hit && mode_ff != RTCC_MODE_CAL |-> !prdata[RTCC_HOURFMT_BIT]
        && (mode_ff != RTCC_MODE_NARROW || !prdata[RTCC_CLEAR_ON_MATCH_BIT]))
        else $error("layout reserved bit nonzero");
    AST_HOURFMT: assert property (@(posedge pclk) disable iff (!presetn)
        mode_ff != RTCC_MODE_CAL |-> !hour_format_select)
        else $error("hour format outside calendar mode");
    AST_IDLE_OK: assert property (@(posedge pclk) disable iff (!presetn)
        sy_ff == RTCC_SY_ACK && !(wr && ctrl_hit) |=> !sync_pending_flag && !soft_reset_bit_ff)
        else $error("busy not cleared after acknowledge");
    AST_SRST_STOPS: assert property (@(posedge rtc_source_clock) disable iff (!rtc_src_rst_n)
        soft_reset_out |-> !counter_run)
        else $error("counter still running during soft reset");
    AST_TICK_IDLE: assert property (@(posedge rtc_source_clock) disable iff (!rtc_src_rst_n)
        !counter_run |=> !counter_tick_clock)
        else $error("tick while stopped");
    COV_EN: cover property (@(posedge pclk) disable iff (!presetn) $rose(enable_ff));
    COV_SR: cover property (@(posedge pclk) disable iff (!presetn) $fell(soft_reset_bit_ff));
    COV_CAL: cover property (@(posedge pclk) disable iff (!presetn) hour_format_select);
    COV_CLR: cover property (@(posedge pclk) disable iff (!presetn) counter_clear);
    COV_SRST: cover property (@(posedge rtc_source_clock) disable iff (!rtc_src_rst_n) soft_reset_out);
endmodule // rtcc_ctrl
`default_nettype wire

// File: verilog/rtcc_pkg.sv
`default_nettype none
package rtcc_pkg;
    // ==========================================
    // register map
    localparam logic [11:0] RTCC_CTRL_OFS = 12'h000;
    localparam logic [11:0] RTCC_STATUS_OFS = 12'h004;
    localparam logic [11:0] RTCC_PROT_OFS = 12'h008;
    localparam logic [15:0] RTCC_CTRL_RST = 16'h0000;
    // ==========================================
    // control fields
    localparam int RTCC_SOFT_RESET_BIT_BIT = 0;
    localparam int RTCC_ENABLE_BIT = 1;
    localparam int RTCC_MODE_LSB = 2;
    localparam int RTCC_HOURFMT_BIT = 6;
    localparam int RTCC_CLEAR_ON_MATCH_BIT = 7;
    localparam int RTCC_PRESC_LSB = 8;
    localparam int RTCC_SYNC_PENDING_FLAG_BIT = 7;
    localparam logic [3:0] RTCC_PRESC_MAX = 4'hA;
    // ==========================================
    // modes and sync states
    typedef enum logic [1:0] {
        RTCC_MODE_WIDE = 2'h0,
        RTCC_MODE_NARROW = 2'h1,
        RTCC_MODE_CAL = 2'h2,
        RTCC_MODE_RSVD = 2'h3
    } rtcc_mode_t;
    typedef enum logic [2:0] {
        RTCC_SY_IDLE = 3'h1,
        RTCC_SY_REQ = 3'h2,
        RTCC_SY_ACK = 3'h4
    } rtcc_sy_t;
endpackage
`default_nettype wire

// File: verilog/rtcc_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
module rtcc_prescaler (
    // counter-domain clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic run,
    input wire logic [3:0] code,
    // tick
    output logic tick
);
    import rtcc_pkg::*;
    logic [9:0] div_ff;
    logic [9:0] nxt_div;
    logic tick_ff;
    logic nxt_tick;
    logic [10:0] lim;
    always_comb begin
        lim = (code > RTCC_PRESC_MAX) ? 11'h001 : (11'h001 << code);
        nxt_div = div_ff;
        nxt_tick = 1'b0;
        if (!run) begin
            nxt_div = 10'h000;
        end else if ({1'b0, div_ff} == lim - 11'h001) begin
            nxt_div = 10'h000;
            nxt_tick = 1'b1;
        end else begin
            nxt_div = div_ff + 10'h001;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_ff <= 10'h000;
            tick_ff <= 1'b0;
        end else begin
            div_ff <= nxt_div;
            tick_ff <= nxt_tick;
        end
    end
    assign tick = tick_ff;
endmodule // rtcc_prescaler
`default_nettype wire

// File: verilog/rtcc_sync2.sv
`timescale 1ns/100ps
`default_nettype none
module rtcc_sync2 (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // level
    input wire logic din,
    output logic dout
);
    logic meta_ff;
    logic sync_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end
    assign dout = sync_ff;
endmodule // rtcc_sync2
`default_nettype wire
